// ### inc/sabi_pkg.sv
// Constants and types shared by the successive-approximation converter control logic
// Overview of operation
// - Read ignored unless chip select low
// - Selected read drives data and starts conversion
// - Mode low selects asynchronous mode
// - Busy falls at start, rises at end
// - Eight data outputs, bit 7 most significant
// - Trial code starts at half scale
// - Record decided bit, set next trial bit
// - After eight decisions, latch result
// - At end raise busy, reset trial code
// - Hold once, or sample per decision
// - Hold on third clock fall after read
// - Slow-memory end loads latches with result
// - Read returns old result, conversion starts
// - Read after busy returns newest result
// - Read within one clock period: no start
// - Asynchronous mode converts continuously
// - Clock pin divided by two, 20 cycles
// - Asynchronous latch deferred while read active
// - Asynchronous mode halts while read active
package sabi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RES_W      = 8;
  localparam int EDGE_CNT_W = 5;

  // ----------------------------------------------------------------
  // Conversion timing in clock-pin cycles
  // ----------------------------------------------------------------
  localparam int CONV_PIN_CYCLES = 20;  // Pin cycles per conversion
  localparam int CONV_INT_CYCLES = 10;  // Internal cycles, pin clock halved
  localparam int PIN_PER_INT     = CONV_PIN_CYCLES / CONV_INT_CYCLES;
  localparam logic [EDGE_CNT_W-1:0] HOLD_EDGE_IDX  = 5'h02;  // Third fall
  localparam logic [EDGE_CNT_W-1:0] FIRST_DECIDE   = 5'h03;
  localparam logic [EDGE_CNT_W-1:0] LAST_DECIDE    = 5'h11;
  localparam logic [EDGE_CNT_W-1:0] FIRST_SAMPLE   = 5'h02;
  localparam logic [EDGE_CNT_W-1:0] LAST_SAMPLE    = 5'h10;
  localparam logic [EDGE_CNT_W-1:0] END_EDGE_IDX   = 5'(CONV_PIN_CYCLES - 1);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [RES_W-1:0] SAR_HALF    = 8'h80;
  localparam logic [RES_W-1:0] RESULT_RST  = 8'h00;
  localparam logic             BUSY_N_RST  = 1'h1;
  localparam logic             OE_N_RST    = 1'h1;
  localparam logic             PIN_IDLE    = 1'h1;  // Strobes, mode, clock idle high

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SABI_IDLE = 2'b00,
    SABI_CONV = 2'b01,
    SABI_HALT = 2'b10
  } sabi_state_t;

endpackage

// ### src/sabi_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module sabi_pin_sync #(
  parameter int         WIDTH   = 1,
  parameter logic [0:0] RST_VAL = 1'h1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin,
  output var  logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree;

  // Level changes only once stages two and three agree
  assign agree = ~(stage2 ^ stage3);

  // Shift chain; first stage feeds the second only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage1 <= {WIDTH{RST_VAL}};
      stage2 <= {WIDTH{RST_VAL}};
      stage3 <= {WIDTH{RST_VAL}};
      level  <= {WIDTH{RST_VAL}};
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= (agree & stage3) | (~agree & level);
    end
  end

endmodule
`default_nettype wire

// ### src/sabi_sar_adc_ctrl.sv
// Control sequencer and read interface of the 8-bit successive-approximation converter
`timescale 1ns/1ns
`default_nettype none
module sabi_sar_adc_ctrl #(
  parameter bit HAS_TRACK_HOLD = 1'b1,  // Track/hold variant, no mode pin
  parameter bit HAS_MODE_PIN   = 1'b0
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  input  wire logic                      cs_n_pin,
  input  wire logic                      rd_n_pin,
  input  wire logic                      mode_pin,
  input  wire logic                      conv_clk_pin,
  input  wire logic                      comparator_above,
  output var  logic                      busy_n,
  output var  logic [sabi_pkg::RES_W-1:0] result_bits,
  output var  logic                      result_oe_n,
  output var  logic [sabi_pkg::RES_W-1:0] dac_code,
  output var  logic                      hold_active,
  output var  logic                      sample_pulse
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Store decided bit and raise the next lower trial bit
  function automatic logic [sabi_pkg::RES_W-1:0] sar_step(
    input logic [sabi_pkg::RES_W-1:0] code,
    input logic [2:0]                 idx,
    input logic                       above
  );
    logic [sabi_pkg::RES_W-1:0] r;
    r      = code;
    r[idx] = above;
    if (idx != 3'h0) begin
      r[idx - 3'h1] = 1'b1;
    end
    return r;
  endfunction

  // True when count lies inside an inclusive window
  function automatic logic in_window(
    input logic [sabi_pkg::EDGE_CNT_W-1:0] cnt,
    input logic [sabi_pkg::EDGE_CNT_W-1:0] lo,
    input logic [sabi_pkg::EDGE_CNT_W-1:0] hi
  );
    return (cnt >= lo) && (cnt <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [3:0] pin_level;

  sabi_pin_sync #(
    .WIDTH   (4),
    .RST_VAL (sabi_pkg::PIN_IDLE)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin     ({conv_clk_pin, mode_pin, rd_n_pin, cs_n_pin}),
    .level   (pin_level)
  );

  wire cs_s   = pin_level[0];
  wire rd_s   = pin_level[1];
  wire mode_s = pin_level[2];
  wire clk_s  = pin_level[3];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sabi_pkg::sabi_state_t            state;
  sabi_pkg::sabi_state_t            next_state;
  logic [sabi_pkg::EDGE_CNT_W-1:0]  edge_cnt;
  logic [sabi_pkg::RES_W-1:0]       sar;
  logic                             read_active;
  logic                             read_prev;
  logic                             clk_prev;
  logic                             recent_end;
  logic                             int_clk;
  logic [sabi_pkg::RES_W-1:0]       final_code;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // Read counts only while chip select is low
  wire read_now   = ~cs_s & ~rd_s;
  wire read_rise  = read_active & ~read_prev;
  wire pin_fall   = clk_prev & ~clk_s;
  wire async_mode = HAS_MODE_PIN & ~mode_s;
  wire in_idle    = (state == sabi_pkg::SABI_IDLE);
  wire in_conv    = (state == sabi_pkg::SABI_CONV);
  wire in_halt    = (state == sabi_pkg::SABI_HALT);
  wire conv_fall  = in_conv & pin_fall;

  // Decisions fall on every second pin edge, one per internal cycle
  wire decide = conv_fall & int_clk
              & in_window(edge_cnt, sabi_pkg::FIRST_DECIDE, sabi_pkg::LAST_DECIDE);
  wire end_evt  = conv_fall & (edge_cnt == sabi_pkg::END_EDGE_IDX);
  wire hold_evt = conv_fall & (edge_cnt == sabi_pkg::HOLD_EDGE_IDX);
  wire samp_evt = conv_fall & ~int_clk
              & in_window(edge_cnt, sabi_pkg::FIRST_SAMPLE, sabi_pkg::LAST_SAMPLE);

  // Bit under decision: 7 at the first decision down to 0
  wire [3:0] bit_sel = 4'h8 - edge_cnt[4:1];
  wire [2:0] bit_idx = bit_sel[2:0];

  // Start: continuous in asynchronous mode, else on a fresh selected read
  wire sync_start = ~async_mode & read_rise & ~recent_end;
  wire idle_start = in_idle & (async_mode | sync_start);
  wire halt_free  = in_halt & ~read_active;
  wire start      = idle_start | halt_free;

  // Latch at end, unless an asynchronous read defers it to the release
  wire end_defer = end_evt & async_mode & read_active;
  wire latch_now = (end_evt & ~end_defer) | halt_free;

  // A deferred latch takes the code saved at the end; the register is already at half scale
  wire [sabi_pkg::RES_W-1:0] latch_src = halt_free ? final_code : sar;

  // ----------------------------------------------------------------
  // Next-state selection
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      sabi_pkg::SABI_IDLE: begin
        if (idle_start) begin
          next_state = sabi_pkg::SABI_CONV;
        end
      end
      sabi_pkg::SABI_CONV: begin
        if (end_defer) begin
          next_state = sabi_pkg::SABI_HALT;
        end else if (end_evt) begin
          next_state = sabi_pkg::SABI_IDLE;
        end
      end
      sabi_pkg::SABI_HALT: begin
        if (halt_free) begin
          next_state = sabi_pkg::SABI_CONV;
        end
      end
      default: begin
        next_state = sabi_pkg::SABI_IDLE;
      end
    endcase
  end

  // Next values of datapath registers
  wire [sabi_pkg::RES_W-1:0] next_sar =
      (start | end_evt) ? sabi_pkg::SAR_HALF :
      decide ? sar_step(sar, bit_idx, comparator_above) : sar;
  wire [sabi_pkg::EDGE_CNT_W-1:0] next_edge_cnt =
      start ? '0 : (conv_fall ? edge_cnt + 5'h01 : edge_cnt);
  wire next_busy_n = start ? 1'b0 : (end_evt ? 1'b1 : busy_n);
  wire next_hold   = HAS_TRACK_HOLD & ~start & ~end_evt & (hold_evt | hold_active);
  wire next_recent = end_evt | (recent_end & ~pin_fall);

  // ----------------------------------------------------------------
  // Pin history and read tracking
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      read_active <= 1'b0;
      read_prev   <= 1'b0;
      clk_prev    <= sabi_pkg::PIN_IDLE;
    end else begin
      read_active <= read_now;
      read_prev   <= read_active;
      clk_prev    <= clk_s;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and approximation register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state      <= sabi_pkg::SABI_IDLE;
      edge_cnt   <= '0;
      sar        <= sabi_pkg::SAR_HALF;
      busy_n     <= sabi_pkg::BUSY_N_RST;
      recent_end <= 1'b0;
      final_code <= sabi_pkg::RESULT_RST;
    end else begin
      state      <= next_state;
      edge_cnt   <= next_edge_cnt;
      sar        <= next_sar;
      busy_n     <= next_busy_n;
      recent_end <= next_recent;
      final_code <= end_evt ? sar : final_code;
    end
  end

  // Internal clock, half the pin rate, restarted with each conversion
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      int_clk <= 1'b0;
    end else begin
      int_clk <= start ? 1'b0 : (int_clk ^ conv_fall);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      result_bits  <= sabi_pkg::RESULT_RST;
      result_oe_n  <= sabi_pkg::OE_N_RST;
      dac_code     <= sabi_pkg::SAR_HALF;
      hold_active  <= 1'b0;
      sample_pulse <= 1'b0;
    end else begin
      result_bits  <= latch_now ? latch_src : result_bits;
      result_oe_n  <= ~read_active;
      dac_code     <= next_sar;
      hold_active  <= next_hold;
      sample_pulse <= ~HAS_TRACK_HOLD & samp_evt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_sync_read;
    in_idle && !async_mode && read_rise;
  endsequence

  sequence seq_conv_start;
    start ##1 (!busy_n && in_conv && sar == 8'h80);
  endsequence

  a_start_busy_low: assert property (@(posedge sys_clk) disable iff (reset)
    start |-> seq_conv_start)
    else $error("Busy not low with half scale after start");

  a_fresh_read_start: assert property (@(posedge sys_clk) disable iff (reset)
    (seq_sync_read and !recent_end) |=> !busy_n && in_conv)
    else $error("Selected read did not start conversion");

  a_window_no_start: assert property (@(posedge sys_clk) disable iff (reset)
    (seq_sync_read and recent_end) |=> busy_n && in_idle)
    else $error("Read inside end window started conversion");

  a_end_raises_busy: assert property (@(posedge sys_clk) disable iff (reset)
    end_evt |=> busy_n && sar == 8'h80)
    else $error("Conversion end did not raise busy or reset trial code");

  a_latch_result: assert property (@(posedge sys_clk) disable iff (reset)
    (end_evt && !async_mode) |=> result_bits == $past(sar))
    else $error("Result not latched at conversion end");

  a_halt_busy_high: assert property (@(posedge sys_clk) disable iff (reset)
    in_halt |-> busy_n && (result_bits == $past(result_bits)))
    else $error("Halted converter changed busy or result");

  a_async_restart: assert property (@(posedge sys_clk) disable iff (reset)
    (in_idle && async_mode) |=> !busy_n)
    else $error("Asynchronous mode did not restart");

  a_hold_third_fall: assert property (@(posedge sys_clk) disable iff (reset)
    (HAS_TRACK_HOLD && in_conv && !hold_evt && edge_cnt <= sabi_pkg::HOLD_EDGE_IDX)
        |=> !hold_active)
    else $error("Hold asserted before third clock fall");

  a_hold_sets: assert property (@(posedge sys_clk) disable iff (reset)
    (HAS_TRACK_HOLD && hold_evt) |=> hold_active)
    else $error("Hold not taken on third clock fall");

  a_oe_idle_off: assert property (@(posedge sys_clk) disable iff (reset)
    (cs_s && $past(cs_s)) |=> ##1 result_oe_n)
    else $error("Data driven without chip select");

  a_decide_count: assert property (@(posedge sys_clk) disable iff (reset)
    (decide && edge_cnt == 5'h11) |=> dac_code[0] == $past(comparator_above))
    else $error("Last decision not recorded");

  a_defer_keeps: assert property (@(posedge sys_clk) disable iff (reset)
    end_defer |=> in_halt && (result_bits == $past(result_bits)))
    else $error("Deferred end changed the result");

  a_release_latch: assert property (@(posedge sys_clk) disable iff (reset)
    halt_free |=> !busy_n && (result_bits == $past(final_code)))
    else $error("Release did not latch saved code and restart");

  a_oe_on_read: assert property (@(posedge sys_clk) disable iff (reset)
    read_active |=> !result_oe_n)
    else $error("Selected read not driven");

  a_sample_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    (!HAS_TRACK_HOLD && samp_evt) |=> sample_pulse)
    else $error("No sample before decision");

  a_idle_no_start: assert property (@(posedge sys_clk) disable iff (reset)
    (in_idle && !async_mode && !read_rise) |=> busy_n)
    else $error("Synchronous mode started without read");

  a_busy_stays_low: assert property (@(posedge sys_clk) disable iff (reset)
    (in_conv && !end_evt) |=> in_conv && !busy_n)
    else $error("Busy rose before conversion end");

endmodule
`default_nettype wire

// ### bench/sabi_host_model.sv
// Host bus model: selected reads with wait states, plus comparator front end
`timescale 1ns/1ns
`default_nettype none
module sabi_host_model (
  input  wire logic       sys_clk,
  input  wire logic       busy_n,
  input  wire logic [7:0] analog_input_pin,
  input  wire logic [7:0] dac_code,
  output var  logic       cs_n_pin,
  output var  logic       rd_n_pin,
  output var  logic       comparator_above
);
  // Input at or above the trial code keeps the trial bit
  assign comparator_above = (analog_input_pin >= dac_code);

  // Strobes idle high
  initial begin
    cs_n_pin = 1'h1;
    rd_n_pin = 1'h1;
  end

  // Drive read low, chip select as asked, at a rising edge
  task automatic rd_low(input logic cs);
    @(posedge sys_clk);
    cs_n_pin <= cs;
    rd_n_pin <= 1'h0;
  endtask

  // Release both strobes at a rising edge
  task automatic rd_high();
    @(posedge sys_clk);
    cs_n_pin <= 1'h1;
    rd_n_pin <= 1'h1;
  endtask

  // Wait state: strobes stay put while busy is low, no new read meanwhile
  task automatic wait_ready(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (busy_n !== 1'h1 && n < 400);
  endtask
endmodule
`default_nettype wire

// ### bench/sar_adc_bus_interface_tb_top.sv
// Self-checking bench of the converter control sequencer
`timescale 1ns/1ns
`default_nettype none
module sar_adc_bus_interface_tb_top;
  logic       sys_clk    = 1'h0;
  logic       reset      = 1'h1;
  logic       conv_clk   = 1'h1;
  logic [7:0] analog_input_pin        = 8'h00;
  int         fail_count = 0;
  int         n_compared = 0;
  int         cyc        = 0;
  logic       mode_th    = 1'h1;
  logic       mode_as    = 1'h0;
  logic       stray      = 1'h0;
  wire logic       cs_n, rd_n, cmp, busy_n, oe_n, hold, busy_n_a, pulse_a;
  wire logic       pulse_th, hold_a, oe_a;
  wire logic [7:0] result, dac, result_a, dac_a;
  wire logic       cmp_a = (analog_input_pin >= dac_a);

  // System clock, 4 ns period
  initial forever #2 sys_clk = ~sys_clk;

  // Conversion clock pin: 16 system cycles a period, changed at rising edges
  always @(posedge sys_clk) begin
    if (cyc % 8 == 7) conv_clk <= ~conv_clk;
  end

  sabi_host_model hb (.sys_clk(sys_clk), .busy_n(busy_n), .analog_input_pin(analog_input_pin), .dac_code(dac),
    .cs_n_pin(cs_n), .rd_n_pin(rd_n), .comparator_above(cmp));

  sabi_sar_adc_ctrl dut (.sys_clk(sys_clk), .reset(reset), .cs_n_pin(cs_n), .rd_n_pin(rd_n),
    .mode_pin(mode_th), .conv_clk_pin(conv_clk), .comparator_above(cmp), .busy_n(busy_n),
    .result_bits(result), .result_oe_n(oe_n), .dac_code(dac), .hold_active(hold),
    .sample_pulse(pulse_th));

  sabi_sar_adc_ctrl #(.HAS_TRACK_HOLD(1'b0), .HAS_MODE_PIN(1'b1)) dut_async (
    .sys_clk(sys_clk), .reset(reset), .cs_n_pin(cs_n), .rd_n_pin(rd_n), .mode_pin(mode_as),
    .conv_clk_pin(conv_clk), .comparator_above(cmp_a), .busy_n(busy_n_a),
    .result_bits(result_a), .result_oe_n(oe_a), .dac_code(dac_a), .hold_active(hold_a),
    .sample_pulse(pulse_a));

  // Sticky flag: each variant must keep low the sampling output that it does not use
  always @(negedge sys_clk) begin
    if (!reset && (pulse_th !== 1'h0 || hold_a !== 1'h0)) stray <= 1'h1;
  end

  // Comparisons
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic chk_in(input int got, input int lo, input int hi, input string what);
    n_compared++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("FAIL %0t %s count %0d", $time, what, got);
    end
  endtask

  // Wait for the asynchronous instance's busy level, counting sample pulses
  task automatic wait_a(input logic lvl, output int p);
    int n;
    n = 0;
    p = 0;
    while (busy_n_a !== lvl && n < 400) begin
      @(negedge sys_clk);
      n++;
      if (pulse_a === 1'h1) p++;
    end
  endtask

  task automatic t_deselect();
    hb.rd_low(1'h1);
    mode_th <= 1'h0;
    repeat (40) @(negedge sys_clk);
    chk1(busy_n, 1'h1, "started while deselected");
    chk1(oe_n, 1'h0 ^ 1'h1, "driven while deselected");
    hb.rd_high();
    mode_th <= 1'h1;
    $display("test deselect done");
  endtask

  task automatic t_slow(input logic [7:0] v);
    int n;
    int m;
    @(posedge sys_clk);
    analog_input_pin <= v;
    hb.rd_low(1'h0);
    n = 0;
    while (busy_n !== 1'h0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk_in(n, 4, 10, "busy fall after read");
    chk8(dac, 8'h80, "first trial code");
    chk1(hold, 1'h0, "tracking at start");
    n = 0;
    while (hold !== 1'h1 && n < 80) begin
      @(negedge sys_clk);
      n++;
    end
    chk_in(n, 24, 56, "hold on third fall");
    hb.wait_ready(m);
    chk_in(n + m, 290, 336, "conversion length");
    chk8(result, v, "slow-memory result");
    chk1(oe_n, 1'h0, "pending read driven");
    chk8(dac, 8'h80, "trial code back to half");
    chk1(hold, 1'h0, "tracking again");
    hb.rd_high();
    repeat (10) @(negedge sys_clk);
    chk1(oe_n, 1'h1, "bus released");
    $display("test slow memory %h done", v);
  endtask

  task automatic t_rom(input logic [7:0] old, input logic [7:0] v);
    int n;
    @(posedge sys_clk);
    analog_input_pin <= v;
    repeat (40) @(negedge sys_clk);
    hb.rd_low(1'h0);
    repeat (12) @(negedge sys_clk);
    chk8(result, old, "old data on read");
    chk1(oe_n, 1'h0, "read driven");
    hb.rd_high();
    chk1(busy_n, 1'h0, "conversion started by read");
    hb.wait_ready(n);
    hb.rd_low(1'h0);
    repeat (12) @(negedge sys_clk);
    chk8(result, v, "newest data");
    hb.rd_high();
    repeat (40) @(negedge sys_clk);
    chk1(busy_n, 1'h1, "read inside window starts nothing");
    hb.rd_low(1'h0);
    repeat (12) @(negedge sys_clk);
    chk1(busy_n, 1'h0, "read after window restarts");
    hb.rd_high();
    hb.wait_ready(n);
    $display("test rom mode done");
  endtask

  task automatic t_async();
    int p;
    wait_a(1'h1, p);
    wait_a(1'h0, p);
    wait_a(1'h1, p);
    chk_in(p, 8, 8, "samples per conversion");
    chk8(result_a, analog_input_pin, "continuous result");
    @(posedge sys_clk);
    analog_input_pin <= 8'h5a;
    hb.rd_low(1'h0);
    wait_a(1'h0, p);
    wait_a(1'h1, p);
    repeat (50) @(negedge sys_clk);
    chk1(busy_n_a, 1'h1, "halted while read active");
    chk8(result_a, 8'h3c, "latch deferred");
    chk1(oe_a, 1'h0, "async read driven");
    hb.rd_high();
    repeat (12) @(negedge sys_clk);
    chk8(result_a, 8'h5a, "latched on release");
    chk1(busy_n_a, 1'h0, "restart on release");
    chk1(oe_a, 1'h1, "async bus released");
    @(posedge sys_clk);
    mode_as <= 1'h1;
    wait_a(1'h1, p);
    repeat (40) @(negedge sys_clk);
    chk1(busy_n_a, 1'h1, "mode high stops free running");
    chk1(stray, 1'h0, "output of other variant active");
    $display("test asynchronous mode done");
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fail_count++;
      $display("FAIL %0t timeout", $time);
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'h0;
    repeat (10) @(negedge sys_clk);
    chk8(dac, 8'h80, "trial code after reset");
    t_deselect();
    t_slow(8'ha5);
    t_slow(8'h00);
    t_slow(8'hff);
    t_rom(8'hff, 8'h3c);
    t_async();
    tally_and_finish();
  end
endmodule
`default_nettype wire
